// ==== hw/nvea_pkg.sv ====
// Shared constants and types for the data EEPROM access controller
package nvea_pkg;

	// ****************************************
	// Register map
	// ****************************************
	localparam int          ADDR_W          = 3;
	localparam logic [2:0]  OFF_ADDRESS     = 3'h0;
	localparam logic [2:0]  OFF_DATA        = 3'h1;
	localparam logic [2:0]  OFF_CONTROL     = 3'h2;
	localparam logic [2:0]  OFF_UNLOCK      = 3'h3;
	localparam logic [2:0]  OFF_STATUS      = 3'h4;

	// ****************************************
	// Control and status register fields
	// ****************************************
	localparam int          BIT_PROG_SEL    = 7;
	localparam int          BIT_CFG_SEL     = 6;
	localparam int          BIT_ABORT       = 3;
	localparam int          BIT_PERMIT      = 2;
	localparam int          BIT_WTRIG       = 1;
	localparam int          BIT_RTRIG       = 0;
	localparam int          BIT_DONE        = 0;

	// ****************************************
	// Unlock keys, reset values and write cycle length
	// ****************************************
	localparam logic [7:0]  KEY_FIRST       = 8'h55;
	localparam logic [7:0]  KEY_SECOND      = 8'hAA;
	localparam logic [7:0]  RST_BYTE        = 8'h00;
	localparam int          COMMIT_CYCLES   = 400;

	// ****************************************
	// Types
	// ****************************************
	typedef enum logic [1:0] {
		NVEA_LOCKED = 2'b00,
		NVEA_HALF   = 2'b01,
		NVEA_ARMED  = 2'b10
	} nvea_unlock_e;

	typedef enum logic [1:0] {
		NVEA_SP_DATA   = 2'b00,
		NVEA_SP_PROG   = 2'b01,
		NVEA_SP_CONFIG = 2'b10
	} nvea_space_e;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [7:0]        wdata;
		logic              wr;
		logic              rd;
	} nvea_req_s;

endpackage

// ==== hw/nvea_store.sv ====
// Byte-wide data EEPROM array with asynchronous read and clocked write
`timescale 1ns/1ps
`default_nettype none
module nvea_store #(
	parameter int DEPTH_LOG2 = 8
) (
	input  wire logic                  clk,
	input  wire logic                  we,
	input  wire logic [DEPTH_LOG2-1:0] addr,
	input  wire logic [7:0]            wdata,
	output logic      [7:0]            rdata
);
	// Contents survive reset on purpose: it is nonvolatile storage
	logic [7:0] mem [0:(1<<DEPTH_LOG2)-1];

	always_ff @(posedge clk) begin
		if (we) begin
			mem[addr] <= wdata;
		end
	end

	assign rdata = mem[addr];
endmodule
`default_nettype wire

// ==== hw/nvea_top.sv ====
// Register-driven access controller for the on-chip data EEPROM
//
// What this block does
// - Read byte lands in the data register before the next instruction cycle.
// - Data register keeps the read byte until a new read or software write.
// - Write starts only after 55h then AAh to unlock, then trigger.
// - Write trigger cannot be set while the write permit bit is clear.
// - Permit must be set by an earlier write than the trigger.
// - Hardware never clears the write permit bit.
// - During a write, control, address and data registers are frozen.
// - On completion hardware clears the write trigger and sets done flag.
// - Unlock register has no storage and always reads as zero.
// - Software can set but never clear the write trigger bit.
// - A master or watchdog reset during a write sets the abort flag.
// - Config select overrides program select; else program select picks space.
//
// The register addresses and the strobed register port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module nvea_top #(
	parameter int DEPTH_LOG2    = 8,
	parameter int COMMIT_CYCLES = nvea_pkg::COMMIT_CYCLES
) (
	input  wire logic                  clk,
	input  wire logic                  srst,
	input  wire nvea_pkg::nvea_req_s   req,
	output logic      [7:0]            rdata,
	input  wire logic                  mclr_reset,
	input  wire logic                  wdt_reset,
	output logic                       commit_done_flag,
	output logic                       commit_busy,
	output nvea_pkg::nvea_space_e      space_sel
);

	// ****************************************
	// Register state
	// ****************************************
	localparam int CNT_W = $clog2(COMMIT_CYCLES + 1);

	logic [DEPTH_LOG2-1:0]  nv_address_reg;
	logic [7:0]             nv_data_reg;
	logic                   program_space_select;
	logic                   config_space_select;
	logic                   commit_permit_bit;
	logic                   commit_abort_flag;
	logic                   write_trigger;
	logic [CNT_W-1:0]       commit_cnt;
	nvea_pkg::nvea_unlock_e unlock_state;
	nvea_pkg::nvea_unlock_e next_unlock_state;
	logic [7:0]             store_rdata;
	logic                   store_we;
	logic                   core_reset;
	logic                   wr_addr;
	logic                   wr_data;
	logic                   wr_ctrl;
	logic                   wr_unlock;
	logic                   wr_status;
	logic                   key_first;
	logic                   key_second;
	logic                   read_go;
	logic                   commit_go;
	logic                   commit_end;
	logic                   data_space;
	logic [7:0]             next_rdata;

	// A master or watchdog reset acts like srst on the working registers
	assign core_reset = srst | mclr_reset | wdt_reset;

	assign wr_addr   = req.wr && req.addr == nvea_pkg::OFF_ADDRESS;
	assign wr_data   = req.wr && req.addr == nvea_pkg::OFF_DATA;
	assign wr_ctrl   = req.wr && req.addr == nvea_pkg::OFF_CONTROL;
	assign wr_unlock = req.wr && req.addr == nvea_pkg::OFF_UNLOCK;
	assign wr_status = req.wr && req.addr == nvea_pkg::OFF_STATUS;

	// ****************************************
	// Space selection
	// ****************************************
	// Config select dominates, so one bit fences off both memories
	always_comb begin
		if (config_space_select) begin
			space_sel = nvea_pkg::NVEA_SP_CONFIG;
		end else if (program_space_select) begin
			space_sel = nvea_pkg::NVEA_SP_PROG;
		end else begin
			space_sel = nvea_pkg::NVEA_SP_DATA;
		end
	end

	// Only the data space is served here; other spaces leave storage alone
	assign data_space = space_sel == nvea_pkg::NVEA_SP_DATA;

	// ****************************************
	// Unlock key decode
	// ****************************************
	// A key counts only when it is written to the unlock register itself
	assign key_first  = wr_unlock && req.wdata == nvea_pkg::KEY_FIRST;
	assign key_second = wr_unlock && req.wdata == nvea_pkg::KEY_SECOND;

	// ****************************************
	// Unlock sequencer
	// ****************************************
	// Any bus write other than the next expected step or a repeated first key breaks the sequence
	always_comb begin
		next_unlock_state = unlock_state;
		case (unlock_state)
			nvea_pkg::NVEA_LOCKED: begin
				if (key_first) begin
					next_unlock_state = nvea_pkg::NVEA_HALF;
				end
			end
			nvea_pkg::NVEA_HALF: begin
				if (key_second) begin
					next_unlock_state = nvea_pkg::NVEA_ARMED;
				end else if (req.wr && !key_first) begin
					next_unlock_state = nvea_pkg::NVEA_LOCKED;
				end
			end
			nvea_pkg::NVEA_ARMED: begin
				// A fresh first key restarts; any other write disarms
				if (key_first) begin
					next_unlock_state = nvea_pkg::NVEA_HALF;
				end else if (req.wr) begin
					next_unlock_state = nvea_pkg::NVEA_LOCKED;
				end
			end
			default: begin
				next_unlock_state = nvea_pkg::NVEA_LOCKED;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (core_reset) begin
			unlock_state <= nvea_pkg::NVEA_LOCKED;
		end else begin
			unlock_state <= next_unlock_state;
		end
	end

	// ****************************************
	// Trigger decode
	// ****************************************
	// Permit is tested as already stored, so one write cannot set both
	assign commit_go = wr_ctrl && !write_trigger
		&& req.wdata[nvea_pkg::BIT_WTRIG]
		&& commit_permit_bit
		&& unlock_state == nvea_pkg::NVEA_ARMED;

	// A read trigger while busy is dropped, so the data register stays put
	assign read_go = wr_ctrl && !write_trigger
		&& req.wdata[nvea_pkg::BIT_RTRIG];

	assign commit_end = write_trigger
		&& commit_cnt == CNT_W'(COMMIT_CYCLES - 1);

	// ****************************************
	// Control register
	// ****************************************
	always_ff @(posedge clk) begin
		if (core_reset) begin
			program_space_select <= 1'b0;
			config_space_select  <= 1'b0;
			commit_permit_bit    <= 1'b0;
		end else if (wr_ctrl && !write_trigger) begin
			// Unused bits and the read trigger keep no state
			program_space_select <= req.wdata[nvea_pkg::BIT_PROG_SEL];
			config_space_select  <= req.wdata[nvea_pkg::BIT_CFG_SEL];
			// Only a software write changes the permit bit
			commit_permit_bit    <= req.wdata[nvea_pkg::BIT_PERMIT];
		end
	end

	// ****************************************
	// Write cycle timer
	// ****************************************
	always_ff @(posedge clk) begin
		if (core_reset) begin
			write_trigger <= 1'b0;
			commit_cnt    <= '0;
		end else if (commit_go) begin
			write_trigger <= 1'b1;
			commit_cnt    <= '0;
		end else if (commit_end) begin
			write_trigger <= 1'b0;
			commit_cnt    <= '0;
		end else if (write_trigger) begin
			commit_cnt    <= commit_cnt + CNT_W'(1);
		end
	end

	// Storage is written on the closing edge, with address and data frozen
	assign commit_busy = write_trigger;
	assign store_we    = commit_end && data_space;

	// ****************************************
	// Abort flag
	// ****************************************
	// Cleared only by power-on reset or by software, so it tells of the loss
	always_ff @(posedge clk) begin
		if (srst) begin
			commit_abort_flag <= 1'b0;
		end else if ((mclr_reset || wdt_reset) && write_trigger) begin
			commit_abort_flag <= 1'b1;
		end else if (wr_ctrl && !write_trigger
			&& !req.wdata[nvea_pkg::BIT_ABORT]) begin
			commit_abort_flag <= 1'b0;
		end
	end

	// ****************************************
	// Done flag
	// ****************************************
	// Write one to clear; a completion in the same cycle wins
	always_ff @(posedge clk) begin
		if (core_reset) begin
			commit_done_flag <= 1'b0;
		end else if (commit_end) begin
			commit_done_flag <= 1'b1;
		end else if (wr_status && req.wdata[nvea_pkg::BIT_DONE]) begin
			commit_done_flag <= 1'b0;
		end
	end

	// ****************************************
	// Address and data registers
	// ****************************************
	always_ff @(posedge clk) begin
		if (core_reset) begin
			nv_address_reg <= '0;
		end else if (wr_addr && !write_trigger) begin
			nv_address_reg <= req.wdata[DEPTH_LOG2-1:0];
		end
	end

	always_ff @(posedge clk) begin
		if (core_reset) begin
			nv_data_reg <= nvea_pkg::RST_BYTE;
		end else if (read_go && data_space) begin
			nv_data_reg <= store_rdata;
		end else if (wr_data && !write_trigger) begin
			nv_data_reg <= req.wdata;
		end
	end

	// Read is combinational, so a read trigger loads the byte on its own edge
	nvea_store #(
		.DEPTH_LOG2 (DEPTH_LOG2)
	) u_store (
		.clk   (clk),
		.we    (store_we),
		.addr  (nv_address_reg),
		.wdata (nv_data_reg),
		.rdata (store_rdata)
	);

	// ****************************************
	// Read-back
	// ****************************************
	// Reads have no side effects, so polling the status is always safe
	always_comb begin
		next_rdata = 8'h00;
		case (req.addr)
			nvea_pkg::OFF_ADDRESS: begin
				next_rdata = 8'(nv_address_reg);
			end
			nvea_pkg::OFF_DATA: begin
				next_rdata = nv_data_reg;
			end
			nvea_pkg::OFF_CONTROL: begin
				next_rdata[nvea_pkg::BIT_PROG_SEL] = program_space_select;
				next_rdata[nvea_pkg::BIT_CFG_SEL]  = config_space_select;
				next_rdata[nvea_pkg::BIT_ABORT]    = commit_abort_flag;
				next_rdata[nvea_pkg::BIT_PERMIT]   = commit_permit_bit;
				next_rdata[nvea_pkg::BIT_WTRIG]    = write_trigger;
			end
			nvea_pkg::OFF_UNLOCK: begin
				next_rdata = 8'h00;
			end
			nvea_pkg::OFF_STATUS: begin
				next_rdata[nvea_pkg::BIT_DONE] = commit_done_flag;
			end
			default: begin
				next_rdata = 8'h00;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			rdata <= 8'h00;
		end else if (req.rd) begin
			rdata <= next_rdata;
		end else begin
			rdata <= 8'h00;
		end
	end

endmodule
`default_nettype wire

// ==== testbench/nvea_props.sv ====
// Port checker for the data EEPROM access controller
`timescale 1ns/1ps
`default_nettype none
module nvea_props #(
	parameter int COMMIT_CYCLES = nvea_pkg::COMMIT_CYCLES
) (
	input wire logic                clk,
	input wire logic                srst,
	input wire nvea_pkg::nvea_req_s req,
	input wire logic [7:0]          rdata,
	input wire logic                mclr_reset,
	input wire logic                wdt_reset,
	input wire logic                commit_done_flag,
	input wire logic                commit_busy
);
	default clocking @(posedge clk); endclocking
	default disable iff (srst);

	// ****************************************
	// Helpers
	// ****************************************
	// Busy samples so far; a reset event cuts a write short
	int   cnt;
	logic hit;
	logic trig_wr;
	assign hit     = mclr_reset || wdt_reset;
	assign trig_wr = req.wr && req.addr == nvea_pkg::OFF_CONTROL
		&& req.wdata[nvea_pkg::BIT_WTRIG];
	always_ff @(posedge clk) begin
		if (srst || !commit_busy) begin
			cnt <= 0;
		end else begin
			cnt <= cnt + 1;
		end
	end
	sequence s_finish;
		$fell(commit_busy) && !$past(hit);
	endsequence
	// ****************************************
	// Properties
	// ****************************************
	a_unlock_zero: assert property (
		req.rd && req.addr == nvea_pkg::OFF_UNLOCK |=> rdata == 8'h00)
		else $error("unlock register read not zero");
	a_start_cause: assert property (
		$rose(commit_busy) |-> $past(trig_wr))
		else $error("write started without trigger");
	a_commit_length: assert property (
		s_finish |-> cnt == COMMIT_CYCLES)
		else $error("write cycle length wrong");
	a_trig_holds: assert property (
		commit_busy && !hit && cnt < COMMIT_CYCLES - 1 |=> commit_busy)
		else $error("write trigger cleared early");
	a_done_finish: assert property (
		s_finish |-> commit_done_flag)
		else $error("done flag missing at completion");
	a_done_cause: assert property (
		$rose(commit_done_flag) |-> $fell(commit_busy))
		else $error("done flag set without completion");
	a_done_sticky: assert property (
		commit_done_flag && !hit && !(req.wr
		&& req.addr == nvea_pkg::OFF_STATUS
		&& req.wdata[nvea_pkg::BIT_DONE]) |=> commit_done_flag)
		else $error("done flag cleared by hardware");
	a_read_answer: assert property (
		rdata != 8'h00 |-> $past(req.rd))
		else $error("read data without read strobe");
endmodule
bind nvea_top nvea_props #(.COMMIT_CYCLES(COMMIT_CYCLES)) nvea_props_i (
	.clk(clk), .srst(srst), .req(req), .rdata(rdata),
	.mclr_reset(mclr_reset), .wdt_reset(wdt_reset),
	.commit_done_flag(commit_done_flag), .commit_busy(commit_busy));
`default_nettype wire

// ==== testbench/nvea_top_tb_top.sv ====
// Self-checking bench for the data EEPROM access controller
`timescale 1ns/1ps
`default_nettype none
module nvea_top_tb_top;
	localparam int N = 8;
	logic                  clk = 1'b0;
	logic                  srst = 1'b1;
	nvea_pkg::nvea_req_s   req = '0;
	logic [7:0]            rdata;
	logic                  mclr_reset = 1'b0;
	logic                  wdt_reset = 1'b0;
	logic                  commit_done_flag;
	logic                  commit_busy;
	nvea_pkg::nvea_space_e space_sel;
	int                    err_count = 0;
	int                    checks_done = 0;
	int                    cycles = 0;
	nvea_top #(.COMMIT_CYCLES(N)) nvea_top_i (
		.clk(clk), .srst(srst), .req(req), .rdata(rdata),
		.mclr_reset(mclr_reset), .wdt_reset(wdt_reset),
		.commit_done_flag(commit_done_flag),
		.commit_busy(commit_busy), .space_sel(space_sel));
	// ****************************************
	// Bus tasks
	// ****************************************
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		checks_done++;
		if (seen !== exp) begin
			err_count++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge clk);
		req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge clk);
		req <= '0;
	endtask
	task automatic rdc(input logic [2:0] a, input logic [7:0] exp);
		@(posedge clk);
		req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge clk);
		req <= '0;
		#1 chk(rdata, exp);
	endtask
	// Full unlock sequence; permit goes in its own write, three writes ahead of the trigger
	task automatic start(input logic [7:0] a, input logic [7:0] d);
		wr(nvea_pkg::OFF_ADDRESS, a);
		wr(nvea_pkg::OFF_DATA, d);
		wr(nvea_pkg::OFF_CONTROL, 8'h04);
		wr(nvea_pkg::OFF_UNLOCK, nvea_pkg::KEY_FIRST);
		wr(nvea_pkg::OFF_UNLOCK, nvea_pkg::KEY_SECOND);
		wr(nvea_pkg::OFF_CONTROL, 8'h06);
		#1;
	endtask
	task automatic wait_idle;
		for (int i = 0; i < 40 && commit_busy !== 1'b0; i++) begin
			@(posedge clk);
			#1;
		end
	endtask
	// ****************************************
	// Scenarios
	// ****************************************
	task automatic s_commit;
		start(8'h05, 8'hA5);
		chk(commit_busy, 1'b1);
		wr(nvea_pkg::OFF_DATA, 8'h11);
		wr(nvea_pkg::OFF_ADDRESS, 8'h02);
		wr(nvea_pkg::OFF_CONTROL, 8'h00);
		#1 chk(commit_busy, 1'b1);
		wait_idle();
		chk(commit_done_flag, 1'b1);
		rdc(nvea_pkg::OFF_CONTROL, 8'h04);
		rdc(nvea_pkg::OFF_DATA, 8'hA5);
		rdc(nvea_pkg::OFF_ADDRESS, 8'h05);
		wr(nvea_pkg::OFF_DATA, 8'h00);
		wr(nvea_pkg::OFF_CONTROL, 8'h01);
		rdc(nvea_pkg::OFF_DATA, 8'hA5);
		wr(nvea_pkg::OFF_ADDRESS, 8'h07);
		rdc(nvea_pkg::OFF_DATA, 8'hA5);
		rdc(nvea_pkg::OFF_UNLOCK, 8'h00);
		rdc(3'h5, 8'h00);
		wr(nvea_pkg::OFF_STATUS, 8'h01);
		rdc(nvea_pkg::OFF_STATUS, 8'h00);
	endtask
	// Columns: control before, key, stray index, stray data, key, trigger
	task automatic s_refuse;
		logic [7:0] t [5][6] = '{
			'{8'h00, 8'h55, 8'h03, 8'h55, 8'hAA, 8'h06},
			'{8'h00, 8'h55, 8'h03, 8'h55, 8'hAA, 8'h02},
			'{8'h04, 8'hAA, 8'h03, 8'hAA, 8'h55, 8'h06},
			'{8'h04, 8'h55, 8'h01, 8'h33, 8'hAA, 8'h06},
			'{8'h04, 8'h55, 8'h03, 8'hAA, 8'h00, 8'h06}};
		for (int i = 0; i < 5; i++) begin
			wr(nvea_pkg::OFF_CONTROL, t[i][0]);
			wr(nvea_pkg::OFF_UNLOCK, t[i][1]);
			wr(t[i][2][2:0], t[i][3]);
			wr(nvea_pkg::OFF_UNLOCK, t[i][4]);
			wr(nvea_pkg::OFF_CONTROL, t[i][5]);
			#1 chk(commit_busy, 1'b0);
		end
	endtask
	task automatic s_abort;
		for (int i = 0; i < 2; i++) begin
			start(8'h09, 8'h3C);
			@(posedge clk);
			mclr_reset <= (i == 0);
			wdt_reset <= (i == 1);
			@(posedge clk);
			mclr_reset <= 1'b0;
			wdt_reset <= 1'b0;
			#1 chk(commit_busy, 1'b0);
			rdc(nvea_pkg::OFF_CONTROL, 8'h08);
			wr(nvea_pkg::OFF_CONTROL, 8'h00);
			rdc(nvea_pkg::OFF_CONTROL, 8'h00);
		end
	endtask
	task automatic s_space;
		logic [7:0] c [4] = '{8'h00, 8'h80, 8'h40, 8'hC0};
		logic [7:0] e [4] = '{8'h00, 8'h01, 8'h02, 8'h02};
		for (int i = 0; i < 4; i++) begin
			wr(nvea_pkg::OFF_CONTROL, c[i]);
			#1 chk(space_sel, e[i]);
		end
		// Config space: read and write triggers must leave storage alone
		wr(nvea_pkg::OFF_ADDRESS, 8'h05);
		wr(nvea_pkg::OFF_DATA, 8'h5A);
		wr(nvea_pkg::OFF_CONTROL, 8'hC5);
		rdc(nvea_pkg::OFF_DATA, 8'h5A);
		wr(nvea_pkg::OFF_UNLOCK, nvea_pkg::KEY_FIRST);
		wr(nvea_pkg::OFF_UNLOCK, nvea_pkg::KEY_SECOND);
		wr(nvea_pkg::OFF_CONTROL, 8'hC6);
		#1 chk(commit_busy, 1'b1);
		wait_idle();
		chk(commit_done_flag, 1'b1);
		wr(nvea_pkg::OFF_CONTROL, 8'h00);
		wr(nvea_pkg::OFF_CONTROL, 8'h01);
		rdc(nvea_pkg::OFF_DATA, 8'hA5);
	endtask
	// ****************************************
	// Run control
	// ****************************************
	task automatic end_of_test;
		if (err_count == 0 && checks_done > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	initial begin
		forever #5 clk = ~clk;
	end
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			err_count++;
			end_of_test();
		end
	end
	initial begin
		repeat (3) @(posedge clk);
		srst <= 1'b0;
		s_commit();
		s_refuse();
		s_abort();
		s_space();
		end_of_test();
	end
endmodule
`default_nettype wire
